// ### rtl/csw_ctrl.sv
// Programming control of a 16x16 crosspoint: two-rank latching and lanes
// Operation
// - Each output drives exactly one of 16 inputs, or none, per latched entry.
// - Loading fills the shift rank; a global update rank applies all at once.
// - Disable pin low turns every output off; registers keep their contents.
// - Interface select low means serial loading, high means parallel loading.
// - Clocked data and update transparency only while chip select is low.
// - Serial mode shifts the data pin in on every falling programming clock.
// - Serial word is one 5-bit group per output: four source bits, then enable.
// - Enable bit zero turns the output off and ignores its source bits.
// - Update rank is transparent while update and chip select are low.
// - Chained devices share controls; last device's bits are sent first.
// - Parallel falling edge loads addressed entry; matrix waits for update.
// - Several parallel writes may be collected, then applied by one update.
// - A parallel write changes only the addressed output's entry.
// - An off output stops driving so outputs can share a bus.
// - Source bits give the input number in binary, bit zero least.
// - Address bits give the output number in binary, bit zero least.
`timescale 1ns/1ps
`include "csw_defs.svh"

module csw_ctrl
	import csw_pkg::*;
(
	input  wire logic                         clk_sys_i,
	input  wire logic                         arst_n_i,
	input  wire logic                         clk_en_i,
	input  wire logic                         prog_clk_i,
	input  wire logic                         prog_data_i,
	input  wire logic                         update_n_i,
	input  wire logic                         chip_select_n_i,
	input  wire logic                         interface_select_i,
	input  wire logic [`CSW_ADDR_W-1:0]       output_address_i,
	input  wire logic [`CSW_SRC_W-1:0]        source_select_bits_i,
	input  wire logic                         output_drive_bit_i,
	input  wire logic                         disable_n_i,
	input  wire logic [`CSW_NUM_IN-1:0]       sig_in_i,
	output logic                              serial_out_o,
	output logic [`CSW_NUM_OUT-1:0]           sig_out_o,
	output logic [`CSW_NUM_OUT-1:0]           sig_oe_o,
	output csw_pkg::csw_route_type [`CSW_NUM_OUT-1:0] applied_route_o,
	output logic                              transparent_o
);

	import csw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Group packing

	// Group layout in the shift rank, lowest bit arrives last:
	// bit 4 = source bit 0 ... bit 1 = source bit 3, bit 0 = enable
	function automatic csw_route_type grp_unpack(
		input logic [`CSW_GRP_W-1:0] grp
	);
		csw_route_type r;
		r.drive = grp[`CSW_GRP_DRIVE];
		r.src   = {grp[1], grp[2], grp[3], grp[4]};
		return r;
	endfunction

	function automatic logic [`CSW_GRP_W-1:0] grp_pack(
		input csw_route_type r
	);
		return {r.src[0], r.src[1], r.src[2], r.src[3], r.drive};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	csw_pins_type pins_raw;
	csw_pins_type pins_meta_r;
	csw_pins_type pins_s_r;
	logic [`CSW_NUM_IN-1:0] sig_meta_r;
	logic [`CSW_NUM_IN-1:0] sig_s_r;

	assign pins_raw = '{
		prog_clk:           prog_clk_i,
		prog_data:          prog_data_i,
		update_n:           update_n_i,
		chip_select_n:      chip_select_n_i,
		interface_select:   interface_select_i,
		output_address:     output_address_i,
		source_select_bits: source_select_bits_i,
		output_drive_bit:   output_drive_bit_i,
		disable_n:          disable_n_i
	};

	// Inactive levels at reset so nothing is taken before real pins settle
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pins_meta_r <= '{prog_clk: 1'b0, update_n: 1'b1,
				chip_select_n: 1'b1, disable_n: 1'b0, default: '0};
			pins_s_r    <= '{prog_clk: 1'b0, update_n: 1'b1,
				chip_select_n: 1'b1, disable_n: 1'b0, default: '0};
			sig_meta_r  <= '0;
			sig_s_r     <= '0;
		end else if (clk_en_i) begin
			pins_meta_r <= pins_raw;
			pins_s_r    <= pins_meta_r;
			sig_meta_r  <= sig_in_i;
			sig_s_r     <= sig_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Falling edge of the programming clock

	logic prog_clk_d_r;
	logic fall_edge;
	logic selected;
	logic ser_wr;
	logic par_wr;

	assign fall_edge = prog_clk_d_r & ~pins_s_r.prog_clk;
	assign selected  = ~pins_s_r.chip_select_n;
	assign ser_wr    = fall_edge & selected
		& ~pins_s_r.interface_select;
	assign par_wr    = fall_edge & selected
		& pins_s_r.interface_select;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prog_clk_d_r <= `CSW_CLK_IDLE_RST;
		end else if (clk_en_i) begin
			prog_clk_d_r <= pins_s_r.prog_clk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// First rank: shift register, serially or per group loaded

	logic [`CSW_SHIFT_MSB:0] shift_r;
	logic [`CSW_SHIFT_MSB:0] shift_nxt;
	logic [`CSW_SHIFT_MSB:0] par_nxt;
	csw_route_type           par_route;

	assign par_route = '{src:   pins_s_r.source_select_bits,
		drive: pins_s_r.output_drive_bit};

	genvar g;
	generate
		for (g = 0; g < `CSW_NUM_OUT; g++) begin : gen_grp
			logic hit;
			assign hit = par_wr
				&& (pins_s_r.output_address == `CSW_ADDR_W'(g));
			// Unaddressed groups keep their bits
			assign par_nxt[g*`CSW_GRP_W +: `CSW_GRP_W] = hit
				? grp_pack(par_route)
				: shift_r[g*`CSW_GRP_W +: `CSW_GRP_W];
		end
	endgenerate

	// New bit enters at the bottom, so the first group sent ends up on top
	assign shift_nxt = ser_wr
		? {shift_r[`CSW_SHIFT_MSB-1:0], pins_s_r.prog_data}
		: par_nxt;

	// Contents survive the disable pin; only the system reset clears them
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_r <= `CSW_SHIFT_RST;
		end else if (clk_en_i) begin
			shift_r <= shift_nxt;
		end
	end

	assign serial_out_o = shift_r[`CSW_SHIFT_MSB];

	////////////////////////////////////////////////////////////////////////
	// Second rank: global update latch

	logic [`CSW_SHIFT_MSB:0] applied_r;
	logic                    applied_seen_r;
	logic                    open_latch;

	// Transparent level; while open the matrix tracks every shifted pattern
	assign open_latch    = ~pins_s_r.update_n & selected;
	assign transparent_o = open_latch;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			applied_r      <= `CSW_SHIFT_RST;
			applied_seen_r <= 1'b0;
		end else if (clk_en_i) begin
			if (open_latch) begin
				applied_r      <= shift_r;
				applied_seen_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output lanes

	logic lanes_allowed;

	// Lanes stay off until the update rank has been opened at least once
	assign lanes_allowed = pins_s_r.disable_n & applied_seen_r;

	generate
		for (g = 0; g < `CSW_NUM_OUT; g++) begin : gen_lane
			assign applied_route_o[g] =
				grp_unpack(applied_r[g*`CSW_GRP_W +: `CSW_GRP_W]);

			csw_out_lane u_lane (
				.clk_sys_i (clk_sys_i),
				.arst_n_i  (arst_n_i),
				.clk_en_i  (clk_en_i),
				.sig_in_i  (sig_s_r),
				.route_i   (applied_route_o[g]),
				.allow_i   (lanes_allowed),
				.sig_out_o (sig_out_o[g]),
				.sig_oe_o  (sig_oe_o[g])
			);
		end
	endgenerate

endmodule

// ### common/csw_defs.svh
// Constants of the crosspoint programming control block
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

`define CSW_NUM_OUT      16
`define CSW_NUM_IN       16
`define CSW_SRC_W        4
`define CSW_ADDR_W       4
`define CSW_GRP_W        5
`define CSW_SHIFT_W      80
`define CSW_SHIFT_MSB    79
`define CSW_GRP_DRIVE    0
`define CSW_SHIFT_RST    80'h0
`define CSW_CLK_IDLE_RST 1'b0

`endif

// ### common/csw_pkg.sv
// Types shared by the crosspoint programming control block
`include "csw_defs.svh"

package csw_pkg;

	// One output's routing: source number and drive enable
	typedef struct packed {
		logic [`CSW_SRC_W-1:0] src;
		logic                  drive;
	} csw_route_type;

	// Programming pins after synchronisation
	typedef struct packed {
		logic                   prog_clk;
		logic                   prog_data;
		logic                   update_n;
		logic                   chip_select_n;
		logic                   interface_select;
		logic [`CSW_ADDR_W-1:0] output_address;
		logic [`CSW_SRC_W-1:0]  source_select_bits;
		logic                   output_drive_bit;
		logic                   disable_n;
	} csw_pins_type;

endpackage

// ### rtl/csw_out_lane.sv
// One output lane: registered 16-to-1 selection with drive enable
`timescale 1ns/1ps
`include "csw_defs.svh"

module csw_out_lane
	import csw_pkg::*;
(
	input  wire logic                        clk_sys_i,
	input  wire logic                        arst_n_i,
	input  wire logic                        clk_en_i,
	input  wire logic [`CSW_NUM_IN-1:0]      sig_in_i,
	input  wire csw_pkg::csw_route_type      route_i,
	input  wire logic                        allow_i,
	output logic                             sig_out_o,
	output logic                             sig_oe_o
);

	logic sel_bit;
	logic oe_nxt;

	// Exactly one source when driving, none otherwise
	assign sel_bit = sig_in_i[route_i.src];
	assign oe_nxt  = route_i.drive & allow_i;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sig_out_o <= 1'b0;
			sig_oe_o  <= 1'b0;
		end else if (clk_en_i) begin
			// Data held at zero while off so a shared bus sees no stale level
			sig_out_o <= sel_bit & oe_nxt;
			sig_oe_o  <= oe_nxt;
		end
	end

endmodule

// ### bench/csw_monitor.sv
// Port checker of the crosspoint programming control
`timescale 1ns/1ps
module csw_monitor
	import csw_pkg::*;
(
	input wire logic                         clk_sys_i,
	input wire logic                         arst_n_i,
	input wire logic                         prog_clk_i,
	input wire logic                         update_n_i,
	input wire logic                         chip_select_n_i,
	input wire logic                         disable_n_i,
	input wire logic                         serial_out_o,
	input wire logic [15:0]                  sig_out_o,
	input wire logic [15:0]                  sig_oe_o,
	input wire csw_pkg::csw_route_type [15:0] applied_route_o,
	input wire logic                         transparent_o
);
	import csw_pkg::*;
	logic [15:0] drv;
	always_comb begin
		for (int g = 0; g < 16; g++) begin
			drv[g] = applied_route_o[g].drive;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_off_quiet: assert property ((sig_out_o & ~sig_oe_o) == '0)
		else $error("data on an undriven lane");
	a_oe_needs_drive: assert property ((sig_oe_o & ~$past(drv)) == '0)
		else $error("lane driven without enable");
	a_disable_off: assert property (!disable_n_i [*4] |-> sig_oe_o == '0)
		else $error("lane driven while disabled");
	a_cs_closed: assert property (chip_select_n_i [*4] |-> !transparent_o)
		else $error("update open without select");
	a_upd_closed: assert property (update_n_i [*4] |-> !transparent_o)
		else $error("update open while held");
	a_upd_open: assert property (
		(!update_n_i && !chip_select_n_i) [*4] |-> transparent_o)
		else $error("update rank not open");
	a_route_held: assert property (
		!$past(transparent_o) |-> $stable(applied_route_o))
		else $error("matrix moved while closed");
	a_shift_idle: assert property (
		$stable(prog_clk_i) [*6] |=> $stable(serial_out_o))
		else $error("shift without clock fall");
	a_cs_no_shift: assert property (
		chip_select_n_i [*6] |=> $stable(serial_out_o))
		else $error("shift without select");
endmodule
bind csw_ctrl csw_monitor u_mon (.clk_sys_i, .arst_n_i, .prog_clk_i,
	.update_n_i, .chip_select_n_i, .disable_n_i, .serial_out_o,
	.sig_out_o, .sig_oe_o, .applied_route_o, .transparent_o);

// ### bench/csw_host.sv
// Controller model driving the programming pins
`timescale 1ns/1ps
module csw_host
	import csw_pkg::*;
(
	input  wire logic clk_sys_i,
	output logic       prog_clk_o,
	output logic       prog_data_o,
	output logic       update_n_o,
	output logic       chip_select_n_o,
	output logic       interface_select_o,
	output logic [3:0] output_address_o,
	output logic [3:0] source_select_bits_o,
	output logic       output_drive_bit_o,
	output logic       disable_n_o
);
	import csw_pkg::*;
	initial begin
		{prog_clk_o, update_n_o, chip_select_n_o, disable_n_o} = 4'hf;
		{prog_data_o, interface_select_o, output_drive_bit_o} = 3'h0;
		{output_address_o, source_select_bits_o} = 8'h0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// Four cycles each side keeps pins clear of the sampling window
	task automatic fall();
		cyc(4);
		prog_clk_o <= 1'b0;
		cyc(4);
		prog_clk_o <= 1'b1;
	endtask
	task automatic ser_bit(input logic b, input logic cs_n);
		@(posedge clk_sys_i);
		interface_select_o <= 1'b0;
		chip_select_n_o <= cs_n;
		prog_data_o <= b;
		fall();
		prog_data_o <= ~b;
	endtask
	task automatic ser_word(input logic [79:0] w);
		update_n_o <= 1'b1;
		for (int i = 79; i >= 0; i--) begin
			ser_bit(w[i], 1'b0);
		end
	endtask
	task automatic par_wr(input logic [3:0] a, input csw_route_type r);
		@(posedge clk_sys_i);
		interface_select_o <= 1'b1;
		update_n_o <= 1'b1;
		chip_select_n_o <= 1'b0;
		output_address_o <= a;
		{source_select_bits_o, output_drive_bit_o} <= r;
		fall();
		output_address_o <= ~a;
	endtask
	task automatic upd(input logic cs_n);
		@(posedge clk_sys_i);
		chip_select_n_o <= cs_n;
		update_n_o <= 1'b0;
		cyc(6);
		update_n_o <= 1'b1;
	endtask
	task automatic dis(input logic v);
		@(posedge clk_sys_i);
		disable_n_o <= v;
		cyc(6);
	endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench of the crosspoint programming control
`timescale 1ns/1ps
module testbench;
	import csw_pkg::*;
	logic clk_sys_i, arst_n_i, prog_clk, prog_data, update_n, cs_n;
	logic if_sel, drive_bit, disable_n, ser_out, transp, clk_en;
	logic [3:0] addr, src;
	logic [15:0] sig_in, sig_out, sig_oe;
	logic [79:0] prev;
	csw_route_type [15:0] applied, exp;
	int miscompares, compares, cycles;
	csw_host u_host (.clk_sys_i(clk_sys_i), .prog_clk_o(prog_clk),
		.prog_data_o(prog_data), .update_n_o(update_n),
		.chip_select_n_o(cs_n), .interface_select_o(if_sel),
		.output_address_o(addr), .source_select_bits_o(src),
		.output_drive_bit_o(drive_bit), .disable_n_o(disable_n));
	csw_ctrl u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.clk_en_i(clk_en), .prog_clk_i(prog_clk), .prog_data_i(prog_data),
		.update_n_i(update_n), .chip_select_n_i(cs_n),
		.interface_select_i(if_sel), .output_address_i(addr),
		.source_select_bits_i(src), .output_drive_bit_i(drive_bit),
		.disable_n_i(disable_n), .sig_in_i(sig_in),
		.serial_out_o(ser_out), .sig_out_o(sig_out), .sig_oe_o(sig_oe),
		.applied_route_o(applied), .transparent_o(transp));
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input string what, input logic [79:0] seen, ex);
		compares++;
		if (seen !== ex) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, ex, seen);
		end
	endtask
	function automatic logic [79:0] pack();
		logic [79:0] w;
		for (int g = 0; g < 16; g++) begin
			w[5*g +: 5] = {exp[g].src[0], exp[g].src[1], exp[g].src[2],
				exp[g].src[3], exp[g].drive};
		end
		return w;
	endfunction
	task automatic check_all();
		logic [15:0] m, o;
		for (int g = 0; g < 16; g++) begin
			m[g] = exp[g].drive && disable_n;
			o[g] = m[g] && sig_in[exp[g].src];
		end
		check("route", applied, exp);
		check("drive", {64'h0, sig_oe}, {64'h0, m});
		check("data", {64'h0, sig_out}, {64'h0, o});
	endtask
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Whole run is near 820 cycles; the ceiling leaves ample room
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		{arst_n_i, miscompares, compares, cycles} = '0;
		clk_en = 1'b1;
		sig_in = 16'h5a3c;
		exp = '0;
		repeat (6) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		u_host.cyc(4);
		check_all();
		for (int g = 0; g < 16; g++) begin
			exp[g].src = 4'(g) ^ 4'h5;
			exp[g].drive = (g % 4) != 3;
		end
		u_host.ser_word(pack());
		u_host.cyc(4);
		check("held", applied, 80'h0);
		check("sout", {79'h0, ser_out}, pack() >> 79);
		u_host.upd(1'b0);
		u_host.cyc(2);
		check_all();
		// Refused traffic must leave both ranks alone
		u_host.ser_bit(1'b1, 1'b1);
		u_host.upd(1'b1);
		u_host.cyc(4);
		check("cs", {79'h0, ser_out}, pack() >> 79);
		check_all();
		// A whole bit slot under a frozen enable must leave no trace
		clk_en <= 1'b0;
		u_host.ser_bit(1'b1, 1'b0);
		clk_en <= 1'b1;
		u_host.cyc(6);
		check("frz", {79'h0, ser_out}, pack() >> 79);
		check_all();
		prev = applied;
		exp[0] = {4'hf, 1'b1};
		exp[15] = {4'h0, 1'b1};
		u_host.par_wr(4'h0, exp[0]);
		u_host.par_wr(4'hf, exp[15]);
		u_host.cyc(4);
		check("held2", applied, prev);
		u_host.upd(1'b0);
		u_host.cyc(2);
		check_all();
		u_host.dis(1'b0);
		check("off", {64'h0, sig_oe}, 80'h0);
		// New input levels so the data paths of lanes 0, 1, 2, 5, 6, 10, 14 and 15 are seen moving
		sig_in <= 16'h96e1;
		u_host.dis(1'b1);
		check_all();
		complete_run();
	end
endmodule
